// ==== logic/gpt16_consts.vh ====
// Constants for the two-instance 16-bit general-purpose timer
`ifndef GPT16_CONSTS_VH
`define GPT16_CONSTS_VH
// Register modules holding instance 0 and instance 1
`define GPT16_MOD_INST0 4'h0
`define GPT16_MOD_INST1 4'h3
// Register indices inside a module
`define GPT16_IDX_CTRL 5'h0_0
`define GPT16_IDX_COUNT 5'h0_1
`define GPT16_IDX_COMP 5'h0_2
// Control register field positions
`define GPT16_BIT_RUN 12
`define GPT16_BIT_MODE 11
`define GPT16_BIT_CSEL_HI 10
`define GPT16_BIT_CSEL_LO 9
`define GPT16_BIT_IE 8
`define GPT16_BIT_FLAG 4
`define GPT16_BIT_PS_HI 2
// Reset values
`define GPT16_CTRL_RST 16'h0000
`define GPT16_COUNT_RST 16'h0000
`define GPT16_COMP_RST 16'h0000
// Free-running terminal count
`define GPT16_FREE_TOP 16'hFFFF
// Prescaler terminal counts (divisor minus one)
`define GPT16_PS_DIV1 10'h000
`define GPT16_PS_DIV4 10'h003
`define GPT16_PS_DIV16 10'h00F
`define GPT16_PS_DIV64 10'h03F
`define GPT16_PS_DIV256 10'h0FF
`define GPT16_PS_DIV1024 10'h3FF
`endif

// ==== logic/gpt16_timer.v ====
// Two 16-bit general-purpose timers reached through module/index registers
//
// Behaviour
// - Running counter increments once per prescaled tick
// - Run bit starts; clearing stops and zeroes count
// - Free mode: flag at 0xFFFF, then reload zero
// - Compare mode: flag on match, then reload zero
// - Compare value ignored in free-running mode
// - Clock select: core, peripheral, external input
// - Interrupt request when flag and enable set
// - Flag sticky, hardware sets, software writes zero
// - Prescaler divides 1..1024; codes 11X undivided
// - Two identical instances in modules 0, 3
// - Control register all zero after reset
// - Reserved control bits read zero, ignore writes
// - Peripheral clock runs at twice core rate
// - Count register read-only, resets to zero
`timescale 1ns/1ps
`include "gpt16_consts.vh"

module gpt16_timer (
   input wire core_clk,          // Core clock, 200 MHz
   input wire rst_n,             // Asynchronous reset, active low
   input wire [3:0] sfrModule,   // Register module number of the access
   input wire [4:0] sfrIndex,    // Register index within the module
   input wire sfrWrEn,           // Write strobe, one cycle
   input wire [15:0] sfrWrData,  // Write data
   input wire sfrRdEn,           // Read strobe, one cycle
   input wire extClkPin,         // External timer clock pin, asynchronous
   output reg [15:0] sfrRdData_r, // Read data, valid the cycle after the strobe
   output reg [1:0] irqReq_r     // Interrupt request per instance
);

   ////////////////////////////////////////////////////////////////////////
   // Address decode shared by the write and read paths
   function hit;
      input [3:0] modIn;
      input [4:0] idxIn;
      input [3:0] modWant;
      input [4:0] idxWant;
      begin
         hit = (modIn == modWant) && (idxIn == idxWant);
      end
   endfunction

   // Prescaler terminal count from the three-bit field
   function [9:0] psTop;
      input [2:0] code;
      begin
         case (code)
            3'h1: psTop = `GPT16_PS_DIV4;
            3'h2: psTop = `GPT16_PS_DIV16;
            3'h3: psTop = `GPT16_PS_DIV64;
            3'h4: psTop = `GPT16_PS_DIV256;
            3'h5: psTop = `GPT16_PS_DIV1024;
            default: psTop = `GPT16_PS_DIV1; // Codes 000 and 11X undivided
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Reset release through two flip-flops
   reg rstMeta_r; // First stage, read only by the second
   reg rstSyncN_r; // Reset copy used by the rest of the design

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_r <= 1'b0;
         rstSyncN_r <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSyncN_r <= rstMeta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // External clock pin: two-stage synchroniser and rising-edge detect.
   // Sampling at 200 MHz limits usable external rates well below the pin's
   // upper range; fast inputs will lose edges.
   reg extMeta_r; // First stage, read only by the second
   reg extSync_r; // Synchronised level
   reg extPrev_r; // Previous synchronised level
   wire extEdge; // One-cycle pulse per rising edge

   always @(posedge core_clk or negedge rstSyncN_r) begin
      if (!rstSyncN_r) begin
         extMeta_r <= 1'b0;
         extSync_r <= 1'b0;
         extPrev_r <= 1'b0;
      end else begin
         extMeta_r <= extClkPin;
         extSync_r <= extMeta_r;
         extPrev_r <= extSync_r;
      end
   end

   assign extEdge = extSync_r & ~extPrev_r;

   ////////////////////////////////////////////////////////////////////////
   // Timer instances
   wire [15:0] ctrlRd [0:1]; // Control readback per instance
   wire [15:0] countRd [0:1]; // Count readback per instance
   wire [15:0] compRd [0:1]; // Compare readback per instance
   wire [1:0] irqNxt; // Interrupt level per instance

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : inst
         // Each instance sits in its own register module
         wire [3:0] modNum = (g == 0) ? `GPT16_MOD_INST0 : `GPT16_MOD_INST1;
         wire wrCtrl = sfrWrEn & hit(sfrModule, sfrIndex, modNum, `GPT16_IDX_CTRL);
         wire wrComp = sfrWrEn & hit(sfrModule, sfrIndex, modNum, `GPT16_IDX_COMP);

         reg run_r; // Run control
         reg mode_r; // Mode select, 1 = compare
         reg [1:0] clkSel_r; // Clock source select
         reg ie_r; // Event interrupt enable
         reg flag_r; // Sticky event flag
         reg [2:0] ps_r; // Prescale field
         reg [15:0] count_r; // Count value
         reg [15:0] comp_r; // Compare value
         reg [9:0] pre_r; // Prescaler divider state

         reg [15:0] count_nxt;
         reg [9:0] pre_nxt;
         reg flag_nxt;
         reg hwSet; // Flag-set event this cycle
         reg [1:0] srcTicks; // Source ticks this core cycle
         reg [15:0] top; // Terminal count for the current mode
         integer k;

         // Source tick and counting step; up to two timer clocks per cycle
         always @* begin
            count_nxt = count_r;
            pre_nxt = pre_r;
            hwSet = 1'b0;
            // Compare value only matters in compare mode
            top = mode_r ? comp_r : `GPT16_FREE_TOP;
            // Peripheral source gives two ticks per core cycle
            case (clkSel_r)
               2'h2: srcTicks = 2'h2;
               2'h3: srcTicks = {1'b0, extEdge}; // range kept outside
               default: srcTicks = 2'h1;
            endcase
            for (k = 0; k < 2; k = k + 1) begin
               if (run_r && (srcTicks > k)) begin
                  if (pre_nxt == psTop(ps_r)) begin
                     pre_nxt = 10'h000;
                     // Terminal reached last tick: reload zero now
                     if (count_nxt == top) begin
                        count_nxt = 16'h0000;
                     end else begin
                        count_nxt = count_nxt + 16'h0001;
                     end
                     if (count_nxt == top) begin
                        hwSet = 1'b1;
                     end
                  end else begin
                     pre_nxt = pre_nxt + 10'h001;
                  end
               end
            end
            // Stopped: count and prescaler held at zero
            if (!run_r) begin
               count_nxt = 16'h0000;
               pre_nxt = 10'h000;
            end
            // Hardware set wins over a write of zero
            if (wrCtrl) begin
               flag_nxt = hwSet | (flag_r & sfrWrData[`GPT16_BIT_FLAG]);
            end else begin
               flag_nxt = hwSet | flag_r;
            end
         end

         // Register state
         always @(posedge core_clk or negedge rstSyncN_r) begin
            if (!rstSyncN_r) begin
               {run_r, mode_r, clkSel_r, ie_r} <= 5'h00;
               flag_r <= 1'b0;
               ps_r <= 3'h0;
               count_r <= `GPT16_COUNT_RST;
               comp_r <= `GPT16_COMP_RST;
               pre_r <= 10'h000;
            end else begin
               if (wrCtrl) begin
                  run_r <= sfrWrData[`GPT16_BIT_RUN];
                  mode_r <= sfrWrData[`GPT16_BIT_MODE];
                  clkSel_r <= sfrWrData[`GPT16_BIT_CSEL_HI:`GPT16_BIT_CSEL_LO];
                  ie_r <= sfrWrData[`GPT16_BIT_IE];
                  ps_r <= sfrWrData[`GPT16_BIT_PS_HI:0];
               end
               if (wrComp) begin
                  comp_r <= sfrWrData;
               end
               flag_r <= flag_nxt;
               count_r <= count_nxt; // Writes to the count are ignored
               pre_r <= pre_nxt;
            end
         end

         // Reserved bits read zero
         assign ctrlRd[g] = {3'h0, run_r, mode_r, clkSel_r, ie_r, 3'h0, flag_r, 1'b0, ps_r};
         assign countRd[g] = count_r;
         assign compRd[g] = comp_r;
         assign irqNxt[g] = flag_r & ie_r;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Read mux and registered outputs; unmapped addresses read zero
   reg [15:0] rd_nxt;
   integer i;

   always @* begin
      rd_nxt = 16'h0000;
      for (i = 0; i < 2; i = i + 1) begin
         if (hit(sfrModule, sfrIndex, (i == 0) ? `GPT16_MOD_INST0 : `GPT16_MOD_INST1,
                 `GPT16_IDX_CTRL)) begin
            rd_nxt = ctrlRd[i];
         end
         if (hit(sfrModule, sfrIndex, (i == 0) ? `GPT16_MOD_INST0 : `GPT16_MOD_INST1,
                 `GPT16_IDX_COUNT)) begin
            rd_nxt = countRd[i];
         end
         if (hit(sfrModule, sfrIndex, (i == 0) ? `GPT16_MOD_INST0 : `GPT16_MOD_INST1,
                 `GPT16_IDX_COMP)) begin
            rd_nxt = compRd[i];
         end
      end
   end

   always @(posedge core_clk or negedge rstSyncN_r) begin
      if (!rstSyncN_r) begin
         sfrRdData_r <= 16'h0000;
         irqReq_r <= 2'h0;
      end else begin
         if (sfrRdEn) begin
            sfrRdData_r <= rd_nxt;
         end
         irqReq_r <= irqNxt;
      end
   end

endmodule

// ==== testbench/gpt16_tb.sv ====
// Self-checking bench for the general-purpose timer pair
`timescale 1ns/1ps
module tb;
   reg core_clk = 1'b0; // 200 MHz
   reg rst_n = 1'b0; // Held low at start
   reg [3:0] sfrModule = 4'h0;
   reg [4:0] sfrIndex = 5'h0_0;
   reg sfrWrEn = 1'b0;
   reg [15:0] sfrWrData = 16'h0000;
   reg sfrRdEn = 1'b0;
   reg extClkPin = 1'b0; // 50 MHz, high and low two cycles each
   wire [15:0] sfrRdData_r;
   wire [1:0] irqReq_r;
   reg [15:0] a;
   reg [15:0] b;
   int bad_count = 0;
   int n_checks = 0;
   int k;
   gpt16_timer gpt16_timer_inst (.core_clk(core_clk), .rst_n(rst_n), .sfrModule(sfrModule),
      .sfrIndex(sfrIndex), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn),
      .extClkPin(extClkPin), .sfrRdData_r(sfrRdData_r), .irqReq_r(irqReq_r));
   initial forever #2.5 core_clk = ~core_clk;
   initial forever begin
      repeat (2) @(posedge core_clk);
      #1 extClkPin = ~extClkPin;
   end
   ////////////////////////////////////////////////////////////////////
   task complete_run;
      if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input string nm, input [15:0] e, input [15:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   // Strobes drop after one cycle; an idle cycle keeps drivers apart
   task wr(input [3:0] m, input [4:0] i, input [15:0] d);
      sfrModule = m; sfrIndex = i; sfrWrData = d; sfrWrEn = 1'b1;
      @(posedge core_clk);
      #1 sfrWrEn = 1'b0;
      @(posedge core_clk);
      #1;
   endtask
   task rd(input [3:0] m, input [4:0] i, output [15:0] v);
      sfrModule = m; sfrIndex = i; sfrRdEn = 1'b1;
      @(posedge core_clk);
      #1 sfrRdEn = 1'b0;
      @(posedge core_clk);
      #1 v = sfrRdData_r;
   endtask
   task rdc(input string nm, input [3:0] m, input [4:0] i, input [15:0] e);
      rd(m, i, a);
      chk(nm, e, a);
   endtask
   // Count gained between two reads taken w cycles apart
   task rate(input [15:0] ctl, input int w, input [15:0] e);
      wr(4'h3, 5'h0_0, ctl);
      repeat (20) #5;
      rd(4'h3, 5'h0_1, a);
      repeat (w - 2) #5;
      rd(4'h3, 5'h0_1, b);
      chk("count step", e, b - a);
      wr(4'h3, 5'h0_0, 16'h0000);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      #400000;
      bad_count++;
      complete_run;
   end
   initial begin
      repeat (16) @(posedge core_clk);
      #1 rst_n = 1'b1;
      repeat (4) #5;
      rdc("ctrl0", 4'h0, 5'h0_0, 16'h0000);
      rdc("ctrl3", 4'h3, 5'h0_0, 16'h0000);
      rdc("count", 4'h3, 5'h0_1, 16'h0000);
      wr(4'h0, 5'h0_0, 16'hE0E8);
      rdc("reserved", 4'h0, 5'h0_0, 16'h0000);
      wr(4'h0, 5'h0_1, 16'h1234);
      rdc("count ro", 4'h0, 5'h0_1, 16'h0000);
      rdc("unmapped", 4'h1, 5'h0_0, 16'h0000);
      rdc("bad index", 4'h0, 5'h0_5, 16'h0000);
      for (k = 0; k < 8; k++) rate(16'h1000 | k, 4 * ((k < 6) ? (1 << (2 * k)) : 1), 4);
      rate(16'h1200, 4, 4);
      rate(16'h1400, 10, 20);
      rate(16'h1600, 40, 10);
      // Divider must restart from zero: stop part-way through a period first
      wr(4'h3, 5'h0_0, 16'h1005);
      repeat (500) #5;
      wr(4'h3, 5'h0_0, 16'h0005);
      wr(4'h3, 5'h0_0, 16'h1005);
      repeat (990) #5;
      rdc("first tick", 4'h3, 5'h0_1, 16'h0000);
      repeat (40) #5;
      rdc("tick 1024", 4'h3, 5'h0_1, 16'h0001);
      wr(4'h3, 5'h0_0, 16'h0000);
      // Free-running on the fast clock; compare value must not matter
      wr(4'h0, 5'h0_2, 16'h0005);
      wr(4'h0, 5'h0_0, 16'h1500);
      repeat (100) #5;
      rd(4'h0, 5'h0_1, a);
      chk("past compare", 16'h0001, {15'h0, a > 16'h0005});
      for (k = 0; k < 40000 && irqReq_r[0] !== 1'b1; k++) #5;
      chk("irq0", 16'h0001, {15'h0, irqReq_r[0]});
      rd(4'h0, 5'h0_1, a);
      chk("wrap", 16'h0001, {15'h0, a < 16'h0020});
      rdc("flag", 4'h0, 5'h0_0, 16'h1510);
      wr(4'h0, 5'h0_0, 16'h0100);
      rdc("stopped", 4'h0, 5'h0_1, 16'h0000);
      chk("irq0 off", 16'h0000, {15'h0, irqReq_r[0]});
      wr(4'h0, 5'h0_0, 16'h0000);
      // Compare mode: compare loaded before the mode bit
      wr(4'h3, 5'h0_2, 16'h0009);
      rdc("compare", 4'h3, 5'h0_2, 16'h0009);
      wr(4'h3, 5'h0_0, 16'h1900);
      for (k = 0; k < 100 && irqReq_r[1] !== 1'b1; k++) #5;
      chk("irq1", 16'h0001, {15'h0, irqReq_r[1]});
      for (k = 0; k < 6; k++) begin
         rd(4'h3, 5'h0_1, a);
         chk("cmp count", 16'h0001, {15'h0, a <= 16'h0009});
      end
      // Matches land every ten cycles; clear between them, then on one
      wr(4'h3, 5'h0_0, 16'h1900);
      rdc("flag clear", 4'h3, 5'h0_0, 16'h1900);
      repeat (2) #5;
      wr(4'h3, 5'h0_0, 16'h1900);
      rdc("set wins", 4'h3, 5'h0_0, 16'h1910);
      // Flag sets again with the enable off: no request may follow
      wr(4'h3, 5'h0_0, 16'h1800);
      repeat (8) #5;
      chk("irq1 masked", 16'h0000, {15'h0, irqReq_r[1]});
      rdc("flag masked", 4'h3, 5'h0_0, 16'h1810);
      wr(4'h3, 5'h0_0, 16'h0000);
      complete_run;
   end
endmodule

// ==== testbench/gpt16_timer_props.sv ====
// Port-level assertions for the general-purpose timer pair
`timescale 1ns/1ps
module gpt16_timer_props (
   input wire core_clk, // Core clock
   input wire rst_n, // Async reset, active low
   input wire [3:0] sfrModule, // Access module
   input wire [4:0] sfrIndex, // Access index
   input wire sfrWrEn, // Write strobe
   input wire [15:0] sfrWrData, // Write data
   input wire sfrRdEn, // Read strobe
   input wire extClkPin, // External clock pin
   input wire [15:0] sfrRdData_r, // Read data
   input wire [1:0] irqReq_r // Interrupt requests
);
   // Only modules 0 and 3 hold timers
   wire mapped = sfrModule == 4'h0 || sfrModule == 4'h3;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////
   property p_rd_hold; !sfrRdEn |=> $stable(sfrRdData_r); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_resv; sfrRdEn && mapped && sfrIndex == 5'h0_0 |=> (sfrRdData_r & 16'hE0E8) == 16'h0000;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bits set");
   property p_unmap; sfrRdEn && (!mapped || sfrIndex > 5'h0_2) |=> sfrRdData_r == 16'h0000;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
   property p_irq0; sfrWrEn && sfrModule == 4'h0 && sfrIndex == 5'h0_0 && !sfrWrData[8]
      |=> ##1 !irqReq_r[0]; endproperty
   a_irq0: assert property (p_irq0) else $error("irq0 while disabled");
   property p_irq1; sfrWrEn && sfrModule == 4'h3 && sfrIndex == 5'h0_0 && !sfrWrData[8]
      |=> ##1 !irqReq_r[1]; endproperty
   a_irq1: assert property (p_irq1) else $error("irq1 while disabled");
   // Stop, one idle cycle, then a count read of the same timer gives zero
   property p_stop; sfrWrEn && mapped && sfrIndex == 5'h0_0 && !sfrWrData[12] ##1 !sfrWrEn
      ##1 sfrRdEn && sfrModule == $past(sfrModule, 2) && sfrIndex == 5'h0_1
      |=> sfrRdData_r == 16'h0000; endproperty
   a_stop: assert property (p_stop) else $error("count not cleared on stop");
   property p_comp; sfrWrEn && mapped && sfrIndex == 5'h0_2 ##1 !sfrWrEn
      ##1 sfrRdEn && sfrModule == $past(sfrModule, 2) && sfrIndex == 5'h0_2
      |=> sfrRdData_r == $past(sfrWrData, 3); endproperty
   a_comp: assert property (p_comp) else $error("compare readback wrong");
   // Flag bit left out: hardware may set it at any time
   property p_ctl; sfrWrEn && mapped && sfrIndex == 5'h0_0 ##1 !sfrWrEn
      ##1 sfrRdEn && sfrModule == $past(sfrModule, 2) && sfrIndex == 5'h0_0
      |=> (sfrRdData_r & 16'h1F07) == ($past(sfrWrData, 3) & 16'h1F07); endproperty
   a_ctl: assert property (p_ctl) else $error("control readback wrong");
endmodule
bind gpt16_timer gpt16_timer_props gpt16_timer_props_inst (.*);
